//--- core/strap_map.svh
// Register offsets, field positions, reset values and bus answers
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_STATUS     8'h00
`define OFS_CONFIG     8'h04
`define OFS_RANGE_A    8'h08
`define OFS_RANGE_B    8'h0C
`define OFS_LAYOUT     8'h10
`define OFS_LIVE       8'h14
`define OFS_CMD        8'h18

// ==========================================================
// Word indexes inside the configuration store
`define IDX_CONFIG     2'h0
`define IDX_RANGE_A    2'h1
`define IDX_RANGE_B    2'h2

// ==========================================================
// Configuration word fields
`define CFG_SEQ_BIT    0
`define CFG_BURST_BIT  1
`define CFG_OSR_LSB    2
`define CFG_OSR_MSB    4

// ==========================================================
// Status word fields
`define ST_SW_MODE     0
`define ST_PARALLEL    1
`define ST_EXT_REF     2
`define ST_SEQ         3
`define ST_CHSEL_LSB   4
`define ST_CHSEL_MSB   6
`define ST_RANGE_LSB   8
`define ST_RANGE_MSB   9
`define ST_OSR_LSB     10
`define ST_OSR_MSB     12
`define ST_STALE       14
`define ST_CAPTURED    15

// ==========================================================
// Command word, reset values and bus answers
`define CMD_FULL_RESET 0
`define RST_CONFIG     16'h0000
`define RST_RANGE      16'hFFFF
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

//--- core/strap_pkg.sv
// Types shared by the strap capture and mode selection block
package strap_pkg;

	// ==========================================================
	// Gain range code of one channel; code 0 acts as 10 V
	typedef enum logic [1:0] {
		RNG_DEFAULT,
		RNG_2V5,
		RNG_5V,
		RNG_10V
	} gain_range_e;

	// ==========================================================
	// Read channel sequence of the register slave
	typedef enum logic [1:0] {
		RD_IDLE,
		RD_FETCH,
		RD_SEND
	} rd_state_e;

	// ==========================================================
	// Capture sequence after a full reset
	typedef enum logic [1:0] {
		CAP_PENDING,
		CAP_DONE
	} cap_state_e;

endpackage : strap_pkg

//--- core/cfg_word_store.sv
// Small word store for the software configuration registers
`timescale 1ns/1ps
`include "strap_map.svh"

module cfg_word_store #(
	parameter int                   WIDTH = 16,
	parameter int                   DEPTH = 4,
	parameter int                   AW    = 2,
	parameter logic [WIDTH*DEPTH-1:0] RESET_WORDS = '0
) (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   clear,
	// Write port
	input  wire logic                   wr_en,
	input  wire logic [AW-1:0]          wr_addr,
	input  wire logic [WIDTH/8-1:0]     wr_be,
	input  wire logic [WIDTH-1:0]       wr_data,
	// Read port
	input  wire logic                   rd_en,
	input  wire logic [AW-1:0]          rd_addr,
	output logic      [WIDTH-1:0]       rd_data,
	// All words in parallel
	output logic      [WIDTH*DEPTH-1:0] words
);

	// ==========================================================
	// Storage, one generate step per word and byte lane
	for (genvar w = 0; w < DEPTH; w++)
	begin : g_word
		for (genvar b = 0; b < WIDTH/8; b++)
		begin : g_lane
			always_ff @(posedge aclk)
			begin
				if (!aresetn || clear)
					words[w*WIDTH+b*8 +: 8] <= RESET_WORDS[w*WIDTH+b*8 +: 8];
				else if (wr_en && wr_addr == AW'(w) && wr_be[b])
					words[w*WIDTH+b*8 +: 8] <= wr_data[b*8 +: 8];
			end
		end
	end

	// ==========================================================
	// Registered read data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= words[rd_addr*WIDTH +: WIDTH];
	end

endmodule : cfg_word_store

//--- core/adc_strap_mode_latch.sv
// Strap capture, mode selection and register slave of the dual-core converter
`timescale 1ns/1ps
`include "strap_map.svh"

// Overview of operation
// - Strap levels are captured after reset release and after every full reset.
// - Strap changes take effect only after reset release or a full reset.
// - All range straps low at capture selects register-controlled mode.
// - Host-port strap low at capture selects the parallel host port.
// - In register mode sequence and channel straps are ignored; host ties them low.
// - Reference strap low picks internal reference, high picks external.
// - Pin mode takes sequencer, range and oversampling from dedicated pins.
// - Register mode accepts configuration writes through the selected host port.
// - Two cores, each with eight-input mux, sixteen channels, pairs sampled together.
// - In register mode each channel has its own gain: 2.5 V, 5 V or 10 V bipolar.
// - Oversampling ratio reaches up to 128 times.
// - Each result is a 16-bit successive-approximation code.
// - Configuration registers are 16 bits wide, reachable from either port.
module adc_strap_mode_latch
	import strap_pkg::*;
#(
	parameter int NUM_CORES   = 2,
	parameter int MUX_INPUTS  = 8,
	parameter int RESULT_BITS = 16,
	parameter int OSR_MAX     = 128,
	parameter int REG_BITS    = 16,
	parameter int ADDR_W      = 8
) (
	// Clock and reset
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]               awaddr,
	input  wire logic                            awvalid,
	output logic                                 awready,
	input  wire logic [31:0]                     wdata,
	input  wire logic [3:0]                      wstrb,
	input  wire logic                            wvalid,
	output logic                                 wready,
	// AXI4-Lite write response
	output logic [1:0]                           bresp,
	output logic                                 bvalid,
	input  wire logic                            bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]               araddr,
	input  wire logic                            arvalid,
	output logic                                 arready,
	output logic [31:0]                          rdata,
	output logic [1:0]                           rresp,
	output logic                                 rvalid,
	input  wire logic                            rready,
	// Strap and control pins
	input  wire logic [1:0]                      range_strap_pins,
	input  wire logic                            host_port_select_strap,
	input  wire logic                            sequence_enable_strap,
	input  wire logic [2:0]                      channel_select_straps,
	input  wire logic                            reference_select_strap,
	input  wire logic [2:0]                      osr_strap_pins,
	// Active configuration
	output logic                                 config_ready,
	output logic                                 sw_mode,
	output logic                                 parallel_port_sel,
	output logic                                 ext_ref_sel,
	output logic                                 seq_enable,
	output logic                                 burst_enable,
	output logic [2:0]                           chan_sel,
	output logic [2:0]                           oversampling_ratio,
	output logic [2*NUM_CORES*MUX_INPUTS-1:0]    ch_range
);

	localparam int NUM_CH = NUM_CORES * MUX_INPUTS;

	// ==========================================================
	// Captured straps and capture sequence
	cap_state_e cap_q;
	logic       full_reset_q;
	logic [1:0] range_strap_q;
	logic       port_strap_q;
	logic       seq_strap_q;
	logic [2:0] chsel_strap_q;
	logic       ref_strap_q;
	logic [2:0] osr_strap_q;

	// Host port idles until the first capture edge has passed
	always_ff @(posedge aclk)
	begin
		if (!aresetn || full_reset_q)
			cap_q <= CAP_PENDING;
		else
			cap_q <= CAP_DONE;
	end

	// Strap flops load only on the capture edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			range_strap_q <= 2'h0;
			port_strap_q  <= 1'b0;
			seq_strap_q   <= 1'b0;
			chsel_strap_q <= 3'h0;
			ref_strap_q   <= 1'b0;
			osr_strap_q   <= 3'h0;
		end
		else if (cap_q == CAP_PENDING)
		begin
			range_strap_q <= range_strap_pins;
			port_strap_q  <= host_port_select_strap;
			seq_strap_q   <= sequence_enable_strap;
			chsel_strap_q <= channel_select_straps;
			ref_strap_q   <= reference_select_strap;
			osr_strap_q   <= osr_strap_pins;
		end
	end

	// ==========================================================
	// Mode decode from the captured straps
	wire logic cap_done    = (cap_q == CAP_DONE);
	wire logic sw_mode_w   = (range_strap_q == 2'h0);
	wire logic parallel_w  = !port_strap_q;
	wire logic ext_ref_w   = ref_strap_q;
	wire logic straps_moved = (range_strap_pins != range_strap_q)
		|| (host_port_select_strap != port_strap_q)
		|| (sequence_enable_strap != seq_strap_q)
		|| (channel_select_straps != chsel_strap_q)
		|| (reference_select_strap != ref_strap_q)
		|| (osr_strap_pins != osr_strap_q);

	// ==========================================================
	// Configuration store
	logic [REG_BITS-1:0]   mem_rd_data;
	logic [REG_BITS*4-1:0] mem_words;
	logic                  mem_wr_en;
	logic [1:0]            mem_wr_addr;
	logic [1:0]            mem_rd_addr;
	logic                  mem_rd_en;
	logic [31:0]           wdata_q;
	logic [3:0]            wstrb_q;

	cfg_word_store #(
		.WIDTH       (REG_BITS),
		.DEPTH       (4),
		.AW          (2),
		.RESET_WORDS ({16'h0000, `RST_RANGE, `RST_RANGE, `RST_CONFIG})
	) u_store (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (full_reset_q),
		.wr_en   (mem_wr_en),
		.wr_addr (mem_wr_addr),
		.wr_be   (wstrb_q[1:0]),
		.wr_data (wdata_q[REG_BITS-1:0]),
		.rd_en   (mem_rd_en),
		.rd_addr (mem_rd_addr),
		.rd_data (mem_rd_data),
		.words   (mem_words)
	);

	wire logic [REG_BITS-1:0] cfg_word = mem_words[0 +: REG_BITS];
	wire logic [REG_BITS-1:0] rng_a    = mem_words[REG_BITS +: REG_BITS];
	wire logic [REG_BITS-1:0] rng_b    = mem_words[2*REG_BITS +: REG_BITS];

	// ==========================================================
	// Effective settings: registers in software mode, pins otherwise; channel select is 0 in software mode, burst is 0 in pin mode
	wire logic       seq_d   = sw_mode_w ? cfg_word[`CFG_SEQ_BIT] : seq_strap_q;
	wire logic       burst_d = sw_mode_w && cfg_word[`CFG_BURST_BIT];
	wire logic [2:0] chsel_d = sw_mode_w ? 3'h0 : chsel_strap_q;
	wire logic [2:0] osr_d   = sw_mode_w ? cfg_word[`CFG_OSR_MSB:`CFG_OSR_LSB]
		: osr_strap_q;
	logic [2*NUM_CH-1:0] range_d;

	// One gain code per channel, first core then second
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_chan
		localparam int LANE = 2 * (c % MUX_INPUTS);
		wire logic [1:0] sw_code = (c < MUX_INPUTS) ? rng_a[LANE +: 2] : rng_b[LANE +: 2];
		wire logic [1:0] raw     = sw_mode_w ? sw_code : range_strap_q;
		assign range_d[2*c +: 2] = (raw == RNG_DEFAULT) ? RNG_10V : raw;
	end

	// Registered outputs of the active configuration
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sw_mode            <= 1'b0;
			parallel_port_sel  <= 1'b0;
			ext_ref_sel        <= 1'b0;
			seq_enable         <= 1'b0;
			burst_enable       <= 1'b0;
			chan_sel           <= 3'h0;
			oversampling_ratio <= 3'h0;
			ch_range           <= '0;
		end
		else
		begin
			sw_mode            <= sw_mode_w;
			parallel_port_sel  <= parallel_w;
			ext_ref_sel        <= ext_ref_w;
			seq_enable         <= seq_d;
			burst_enable       <= burst_d;
			chan_sel           <= chsel_d;
			oversampling_ratio <= osr_d;
			ch_range           <= range_d;
		end
	end

	assign config_ready = cap_done;

	// ==========================================================
	// Write channel: address and data taken in either order
	logic              aw_got_q;
	logic              w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;

	assign awready = cap_done && !aw_got_q && !bvalid_q;
	assign wready  = cap_done && !w_got_q && !bvalid_q;
	wire logic aw_hs  = awvalid && awready;
	wire logic w_hs   = wvalid && wready;
	wire logic commit = aw_got_q && w_got_q && !bvalid_q;

	// Write decode
	wire logic wa_cfg   = (awaddr_q == `OFS_CONFIG);
	wire logic wa_rng_a = (awaddr_q == `OFS_RANGE_A);
	wire logic wa_rng_b = (awaddr_q == `OFS_RANGE_B);
	wire logic wa_cmd   = (awaddr_q == `OFS_CMD);
	wire logic wa_store = wa_cfg || wa_rng_a || wa_rng_b;
	wire logic wa_ro    = (awaddr_q == `OFS_STATUS) || (awaddr_q == `OFS_LAYOUT)
		|| (awaddr_q == `OFS_LIVE);
	wire logic wr_ok    = wa_cmd || wa_ro || (wa_store && sw_mode_w);

	assign mem_wr_en   = commit && wa_store && sw_mode_w && cap_done;
	assign mem_wr_addr = wa_cfg ? `IDX_CONFIG : (wa_rng_a ? `IDX_RANGE_A : `IDX_RANGE_B);

	// Address and data holding
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end
		else
		begin
			if (aw_hs)
				awaddr_q <= awaddr;
			if (w_hs)
			begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			aw_got_q <= commit ? 1'b0 : (aw_got_q || aw_hs);
			w_got_q  <= commit ? 1'b0 : (w_got_q || w_hs);
		end
	end

	// Response and software full reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q     <= 1'b0;
			bresp_q      <= `RESP_OKAY;
			full_reset_q <= 1'b0;
		end
		else
		begin
			full_reset_q <= commit && wa_cmd && wstrb_q[0] && wdata_q[`CMD_FULL_RESET];
			if (commit)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (bready)
				bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;

	// ==========================================================
	// Read channel
	rd_state_e         rd_q;
	logic [ADDR_W-1:0] araddr_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	assign arready     = cap_done && (rd_q == RD_IDLE);
	wire logic ar_hs   = arvalid && arready;
	assign mem_rd_en   = ar_hs;
	assign mem_rd_addr = (araddr == `OFS_RANGE_A) ? `IDX_RANGE_A
		: ((araddr == `OFS_RANGE_B) ? `IDX_RANGE_B : `IDX_CONFIG);

	// Status and layout words
	logic [15:0] status_w;
	always_comb
	begin
		status_w = 16'h0000;
		status_w[`ST_SW_MODE]                  = sw_mode_w;
		status_w[`ST_PARALLEL]                 = parallel_w;
		status_w[`ST_EXT_REF]                  = ext_ref_w;
		status_w[`ST_SEQ]                      = seq_d;
		status_w[`ST_CHSEL_MSB:`ST_CHSEL_LSB]  = chsel_d;
		status_w[`ST_RANGE_MSB:`ST_RANGE_LSB]  = range_strap_q;
		status_w[`ST_OSR_MSB:`ST_OSR_LSB]      = osr_d;
		status_w[`ST_STALE]                    = straps_moved;
		status_w[`ST_CAPTURED]                 = cap_done;
	end

	wire logic [31:0] layout_w = {8'(OSR_MAX), 4'(MUX_INPUTS), 4'(NUM_CORES),
		8'(NUM_CH), 8'(RESULT_BITS)};
	wire logic [31:0] live_w = {21'h0, osr_strap_pins, reference_select_strap,
		channel_select_straps, sequence_enable_strap, host_port_select_strap,
		range_strap_pins};

	// Read decode
	wire logic ra_store = (araddr_q == `OFS_CONFIG) || (araddr_q == `OFS_RANGE_A)
		|| (araddr_q == `OFS_RANGE_B);
	wire logic ra_known = ra_store || (araddr_q == `OFS_STATUS)
		|| (araddr_q == `OFS_LAYOUT) || (araddr_q == `OFS_LIVE)
		|| (araddr_q == `OFS_CMD);
	wire logic [31:0] rd_sel = ra_store ? {16'h0000, mem_rd_data}
		: (araddr_q == `OFS_STATUS) ? {16'h0000, status_w}
		: (araddr_q == `OFS_LAYOUT) ? layout_w
		: (araddr_q == `OFS_LIVE)   ? live_w
		: 32'h0000_0000;

	// Read sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_q     <= RD_IDLE;
			araddr_q <= '0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `RESP_OKAY;
		end
		else
		begin
			unique case (rd_q)
				RD_IDLE:
				begin
					if (ar_hs)
					begin
						araddr_q <= araddr;
						rd_q     <= RD_FETCH;
					end
				end
				RD_FETCH:
				begin
					rdata_q <= rd_sel;
					rresp_q <= ra_known ? `RESP_OKAY : `RESP_SLVERR;
					rd_q    <= RD_SEND;
				end
				RD_SEND:
				begin
					if (rready)
						rd_q <= RD_IDLE;
				end
				default:
					rd_q <= RD_IDLE;
			endcase
		end
	end

	assign rvalid = (rd_q == RD_SEND);
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

endmodule : adc_strap_mode_latch

//--- tb/strap_host.sv
// Host-side model that sets the converter's strap pin levels
`timescale 1ns/1ps
module strap_host (
	// Wanted setup
	input  wire logic       want_sw,
	input  wire logic       want_par,
	input  wire logic       want_ext,
	input  wire logic       break_tie,
	input  wire logic [1:0] pin_range,
	input  wire logic       pin_seq,
	input  wire logic [2:0] pin_chsel,
	input  wire logic [2:0] pin_osr,
	// Strap pins
	output logic      [1:0] range_strap_pins,
	output logic            host_port_select_strap,
	output logic            sequence_enable_strap,
	output logic      [2:0] channel_select_straps,
	output logic            reference_select_strap,
	output logic      [2:0] osr_strap_pins
);
	// ==========================================================
	// Static pin levels, sequence and channel straps tied low in register mode unless break_tie
	assign range_strap_pins       = want_sw ? 2'h0 : pin_range;
	assign host_port_select_strap = !want_par;
	assign reference_select_strap = want_ext;
	assign sequence_enable_strap  = (want_sw && !break_tie) ? 1'h0 : pin_seq;
	assign channel_select_straps  = (want_sw && !break_tie) ? 3'h0 : pin_chsel;
	assign osr_strap_pins         = pin_osr;
endmodule : strap_host

//--- tb/adc_strap_assertions.sv
// Port checks of the strap capture and mode selection block
`timescale 1ns/1ps
module adc_strap_assertions (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Register bus
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wvalid,
	input wire logic       wready,
	input wire logic [1:0] bresp,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic       arvalid,
	input wire logic       arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic       rvalid,
	input wire logic       rready,
	// Straps and mode
	input wire logic [1:0] range_strap_pins,
	input wire logic       host_port_select_strap,
	input wire logic       reference_select_strap,
	input wire logic       config_ready,
	input wire logic       sw_mode,
	input wire logic       parallel_port_sel,
	input wire logic       ext_ref_sel,
	input wire logic [2:0] chan_sel
);
	// ==========================================================
	// Shared clocking and bus steps
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	sequence cap_done;
		$rose(config_ready);
	endsequence

	// ==========================================================
	// Bus gating and answers
	ready_gate_a: assert property (!config_ready |-> !awready && !wready && !arready)
		else $error("bus ready before capture");
	write_answer_a: assert property (wr_take |-> !bvalid ##1 !bvalid ##1 bvalid)
		else $error("write answer late");
	read_answer_a: assert property (rd_take |-> ##2 rvalid)
		else $error("read answer late");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
		else $error("read answer dropped");

	// ==========================================================
	// Strap capture and hold
	strap_hold_a: assert property (config_ready && $past(config_ready)
		&& $past(config_ready, 2) && $past(config_ready, 3)
		|-> $stable({sw_mode, parallel_port_sel, ext_ref_sel}))
		else $error("mode moved without capture");
	sw_capture_a: assert property (cap_done |=> sw_mode == ($past(range_strap_pins, 2) == 2'h0))
		else $error("mode capture wrong");
	port_capture_a: assert property (cap_done |=> parallel_port_sel == !$past(host_port_select_strap, 2))
		else $error("port capture wrong");
	ref_capture_a: assert property (cap_done |=> ext_ref_sel == $past(reference_select_strap, 2))
		else $error("reference capture wrong");
	sw_chan_zero_a: assert property (config_ready && sw_mode |-> chan_sel == 3'h0)
		else $error("channel strap used in register mode");
endmodule : adc_strap_assertions

//--- tb/adc_strap_mode_latch_bench.sv
// Self-checking bench of the strap capture and mode selection block
`timescale 1ns/1ps
`include "strap_map.svh"
`define CHK(x, y) \
	begin \
		tests_run++; \
		if ((x) !== (y)) \
		begin \
			bad_count++; \
			$display("[ERR] %0t got %h exp %h", $time, (x), (y)); \
		end \
	end
module adc_strap_mode_latch_bench;
	// ==========================================================
	// Signals and table rows
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] wd;
		logic [1:0]  br;
		logic [31:0] rd;
		logic [1:0]  rr;
	} row_s;
	row_s rows [6] = '{
		'{`OFS_CONFIG, 32'h0000001F, `RESP_OKAY, 32'h0000001F, `RESP_OKAY},
		'{`OFS_RANGE_A, 32'hFFFF5A7C, `RESP_OKAY, 32'h00005A7C, `RESP_OKAY},
		'{`OFS_RANGE_B, 32'h0000E5B9, `RESP_OKAY, 32'h0000E5B9, `RESP_OKAY},
		'{`OFS_LAYOUT, 32'h00000000, `RESP_OKAY, 32'h80821010, `RESP_OKAY},
		'{`OFS_CMD, 32'h00000000, `RESP_OKAY, 32'h00000000, `RESP_OKAY},
		'{8'h1C, 32'h00001234, `RESP_SLVERR, 32'h00000000, `RESP_SLVERR}};
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        want_sw = 1'h1, want_par = 1'h1, want_ext = 1'h1, break_tie = 1'h0;
	logic [1:0]  pin_range = 2'h2;
	logic        pin_seq = 1'h0;
	logic [2:0]  pin_chsel = 3'h0, pin_osr = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid, config_ready, sw_mode;
	logic        parallel_port_sel, ext_ref_sel, seq_enable, burst_enable;
	logic        host_port_select_strap, sequence_enable_strap, reference_select_strap;
	logic [1:0]  bresp, rresp, range_strap_pins, r;
	logic [2:0]  chan_sel, oversampling_ratio, channel_select_straps, osr_strap_pins;
	logic [31:0] rdata, ch_range, d;
	int          bad_count = 0, tests_run = 0, i;

	// ==========================================================
	// Design and host model
	adc_strap_mode_latch DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .range_strap_pins, .host_port_select_strap,
		.sequence_enable_strap, .channel_select_straps, .reference_select_strap,
		.osr_strap_pins, .config_ready, .sw_mode, .parallel_port_sel, .ext_ref_sel,
		.seq_enable, .burst_enable, .chan_sel, .oversampling_ratio, .ch_range);
	strap_host host (.want_sw, .want_par, .want_ext, .break_tie, .pin_range, .pin_seq,
		.pin_chsel, .pin_osr, .range_strap_pins, .host_port_select_strap,
		.sequence_enable_strap, .channel_select_straps, .reference_select_strap,
		.osr_strap_pins);

	// ==========================================================
	// Clock, verdict and watchdog
	initial
		forever #20 aclk = ~aclk;
	task automatic end_sim;
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (6000) @(posedge aclk);
		bad_count++;
		end_sim();
	end

	// ==========================================================
	// Reset and bus tasks
	task automatic do_reset;
		aresetn <= 1'h0;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		`CHK({awready, wready, arready, bvalid, rvalid, config_ready}, 6'h00)
		@(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
	endtask : do_reset
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] o);
		logic aw_go, w_go, got;
		awaddr  <= a;
		awvalid <= 1'h1;
		wdata   <= v;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do
		begin
			@(negedge aclk);
			aw_go = awvalid && awready;
			w_go  = wvalid && wready;
			got   = bvalid;
			o     = bresp;
			@(posedge aclk);
			if (aw_go)
				awvalid <= 1'h0;
			if (w_go)
				wvalid <= 1'h0;
		end
		while (!got);
		bready <= 1'h0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
		logic ar_go, got;
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do
		begin
			@(negedge aclk);
			ar_go = arvalid && arready;
			got   = rvalid;
			v     = rdata;
			o     = rresp;
			@(posedge aclk);
			if (ar_go)
				arvalid <= 1'h0;
		end
		while (!got);
		rready <= 1'h0;
	endtask : axi_read

	// ==========================================================
	// Main sequence
	initial
	begin
		do_reset();
		`CHK({config_ready, sw_mode, parallel_port_sel, ext_ref_sel}, 4'hF)
		for (i = 0; i < 6; i++)
		begin
			axi_write(rows[i].a, rows[i].wd, r);
			`CHK(r, rows[i].br)
			axi_read(rows[i].a, d, r);
			`CHK({r, d}, {rows[i].rr, rows[i].rd})
		end
		// Status read checked before the new setup is relied on
		axi_read(`OFS_STATUS, d, r);
		`CHK({r, d}, {`RESP_OKAY, 32'h00009C0F})
		`CHK({seq_enable, burst_enable, oversampling_ratio}, 5'h1F)
		`CHK(ch_range, 32'hE5B95A7F)
		// Straps move with no reset
		want_sw   <= 1'h0;
		want_par  <= 1'h0;
		want_ext  <= 1'h0;
		pin_seq   <= 1'h1;
		pin_chsel <= 3'h5;
		pin_osr   <= 3'h3;
		repeat (3) @(posedge aclk);
		`CHK({sw_mode, parallel_port_sel, ext_ref_sel}, 3'h7)
		axi_read(`OFS_STATUS, d, r);
		`CHK(d[15:14], 2'h3)
		// Soft full reset recaptures pin mode
		axi_write(`OFS_CMD, 32'h00000001, r);
		repeat (6) @(posedge aclk);
		`CHK({sw_mode, parallel_port_sel, ext_ref_sel, seq_enable, chan_sel,
			oversampling_ratio}, 10'h06B)
		`CHK(ch_range, 32'hAAAAAAAA)
		axi_write(`OFS_CONFIG, 32'h00000001, r);
		`CHK(r, `RESP_SLVERR)
		axi_read(`OFS_RANGE_A, d, r);
		`CHK(d, {16'h0000, `RST_RANGE})
		// Register mode with straps left high
		want_sw   <= 1'h1;
		want_par  <= 1'h1;
		want_ext  <= 1'h1;
		break_tie <= 1'h1;
		do_reset();
		`CHK({sw_mode, chan_sel, seq_enable}, 5'h10)
		end_sim();
	end
endmodule : adc_strap_mode_latch_bench
bind adc_strap_mode_latch adc_strap_assertions chk (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .range_strap_pins, .host_port_select_strap, .reference_select_strap,
	.config_ready, .sw_mode, .parallel_port_sel, .ext_ref_sel, .chan_sel);
